// File: amux_aes_far.sv
// amux far side: aes receivers delivering skewed frames
`timescale 1ns/1ps
module amux_aes_far #(
  parameter int NLINK = 4,
  parameter int PER   = 100
) (
  // link clock
  input  wire logic                link_clk_in,
  // receiver outputs toward the device
  output logic [NLINK-1:0]         rx_valid_out,
  output logic [NLINK*24-1:0]      rx_left_out,
  output logic [NLINK*24-1:0]      rx_right_out
);
  int cnt = 0;  // position within a frame
  // independent receivers: link l arrives l*20 cycles late, words junk off-pulse
  always @(posedge link_clk_in) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    for (int l = 0; l < NLINK; l++) begin
      rx_valid_out[l] <= (cnt == l * 20);
      rx_left_out[l*24+:24]  <= {8'(2*l), 16'hc3a5} ^ {24{cnt != l * 20}};
      rx_right_out[l*24+:24] <= {8'(2*l+1), 16'hc3a5} ^ {24{cnt != l * 20}};
    end
  end
endmodule : amux_aes_far

// File: amux_cfg.svh
// amux constants: register map, field positions, reset values, timing
`ifndef AMUX_CFG_SVH
`define AMUX_CFG_SVH
// register byte offsets
`define AMUX_OFS_CTRL    4'h0
`define AMUX_OFS_STAT    4'h4
`define AMUX_OFS_RATE    4'h8
// control field positions
`define AMUX_CTRL_RATE_LO  0
`define AMUX_CTRL_FRAME_LO 2
`define AMUX_CTRL_BASE48   4
`define AMUX_CTRL_REFSEL   5
`define AMUX_CTRL_W        6
`define AMUX_CTRL_RST      6'h00
// status field positions
`define AMUX_STAT_LOCK     0
`define AMUX_STAT_SHIFT_LO 1
// sample word and base rates
`define AMUX_WORD_W        24
`define AMUX_BASE_441_HZ   32'h0000_ac44
`define AMUX_BASE_48_HZ    32'h0000_bb80
// lock range and free-run rate of the clock recovery, in Hz
`define AMUX_LOCK_MIN_HZ   28000
`define AMUX_LOCK_MAX_HZ   200000
`define AMUX_NOM_HZ        48000
`endif

// File: amux_checker.sv
// amux checker: bus handshake and link-side output timing
`timescale 1ns/1ps
module amux_checker #(
  parameter int NLINK = 8
) (
  // clocks and reset
  input wire logic                 mclk_in,
  input wire logic                 srst_in,
  input wire logic                 link_clk_in,
  // register bus
  input wire logic [3:0]           avs_address_in,
  input wire logic                 avs_read_in,
  input wire logic                 avs_write_in,
  input wire logic [31:0]          avs_readdata_out,
  input wire logic                 avs_waitrequest_out,
  // link side outputs
  input wire logic                 tx_strobe_out,
  input wire logic [NLINK*24-1:0]  tx_left_out,
  input wire logic [NLINK*24-1:0]  tx_right_out,
  input wire logic                 int_tick_out,
  input wire logic [1:0]           int_index_out,
  input wire logic [NLINK*48-1:0]  int_rx_out
);
  logic [1:0] last_idx_r;   // index of the previous tick
  logic [1:0] last_idx_nxt;
  // remember the tick index so the order inside a frame can be checked
  always_comb last_idx_nxt = int_tick_out ? int_index_out : last_idx_r;
  always_ff @(posedge link_clk_in) last_idx_r <= last_idx_nxt;
  // system reset seen on the link clock, one cycle later than the link side sees it
  logic [2:0] lrs_r = 3'b111;
  always_ff @(posedge link_clk_in) lrs_r <= {lrs_r[1:0], srst_in};
  ////////////////////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property (@(posedge mclk_in) disable iff (srst_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait");
  AST_IDLE: assert property (@(posedge mclk_in) disable iff (srst_in)
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out) else $error("idle wait");
  AST_HOLE: assert property (@(posedge mclk_in) disable iff (srst_in)
    avs_read_in && !avs_waitrequest_out && avs_address_in == 4'hc |-> avs_readdata_out == 0)
    else $error("unmapped read not zero");
  AST_RATE: assert property (@(posedge mclk_in) disable iff (srst_in)
    avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h8 |-> avs_readdata_out inside
    {32'hac44, 32'h15888, 32'h2b110, 32'hbb80, 32'h17700, 32'h2ee00}) else $error("rate");
  AST_TICK: assert property (@(posedge link_clk_in) disable iff (lrs_r[2])
    int_tick_out |=> !int_tick_out) else $error("tick longer than one cycle");
  AST_STROBE: assert property (@(posedge link_clk_in) disable iff (lrs_r[2])
    tx_strobe_out |=> !tx_strobe_out) else $error("strobe longer than one cycle");
  AST_TX_HOLD: assert property (@(posedge link_clk_in) disable iff (lrs_r[2])
    !tx_strobe_out |-> $stable(tx_left_out) && $stable(tx_right_out)) else $error("tx moved");
  AST_RX_HOLD: assert property (@(posedge link_clk_in) disable iff (lrs_r[2])
    !int_tick_out |-> $stable(int_rx_out)) else $error("rx moved between ticks");
  AST_ORDER: assert property (@(posedge link_clk_in) disable iff (lrs_r[2])
    int_tick_out && int_index_out != 2'h0 |-> int_index_out == last_idx_r + 2'h1)
    else $error("tick index out of order");
endmodule : amux_checker

// File: amux_core.sv
// amux core: register slave, clock recovery, sample split and join
`timescale 1ns/1ps
`include "amux_cfg.svh"
// Summary of operation
// - double rate doubles the internal sample clock
// - internal words stay 24 bits wide
// - double wire: one channel, samples alternate subframes
// - 96k as split 48k frame or native
// - 48k frame double rate: two channels each
// - 192k as 48k, 96k or native frame
// - 48k frame quad rate: four channels each
// - two-way split also on double rate links
// - samples only moved, never altered or dropped
// - single wire: sample rate equals frame rate
// - recovery locks 28k to 200k, tracks phase
// - recovered clock drives transmitters and word clock
// - received pairs realigned to the same sample
module amux_core
  import amux_pkg::*;
#(
  parameter int NLINK   = 8,
  parameter int LCLK_HZ = 66666667
) (
  // system clock, reset and freeze
  input  wire logic                      mclk_in,
  input  wire logic                      srst_in,
  input  wire logic                      clk_en_in,
  // avalon-mm register slave
  input  wire logic [3:0]                avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  // link clock and receivers
  input  wire logic                      link_clk_in,
  input  wire logic [NLINK-1:0]          rx_valid_in,
  input  wire logic [NLINK*24-1:0]       rx_left_in,
  input  wire logic [NLINK*24-1:0]       rx_right_in,
  input  wire logic                      wck_in,
  // transmitters and word clock
  output logic                           tx_strobe_out,
  output logic      [NLINK*24-1:0]       tx_left_out,
  output logic      [NLINK*24-1:0]       tx_right_out,
  output logic                           wck_out,
  // internal high-rate channel side, link clock
  output logic                           int_tick_out,
  output logic      [1:0]                int_index_out,
  input  wire logic [NLINK*48-1:0]       int_tx_in,
  output logic      [NLINK*48-1:0]       int_rx_out
);
  localparam int NCH  = 2 * NLINK;
  localparam int W    = `AMUX_WORD_W;
  // period bounds in link cycles, derived from the rates
  localparam int PMAX = LCLK_HZ / `AMUX_LOCK_MIN_HZ;
  localparam int PMIN = (LCLK_HZ + `AMUX_LOCK_MAX_HZ - 1) / `AMUX_LOCK_MAX_HZ;
  localparam int PNOM = LCLK_HZ / `AMUX_NOM_HZ;
  localparam int PW   = $clog2(PMAX + 2);

  // split factor as a shift: 0 none, 1 two-way, 2 four-way
  function automatic logic [1:0] split_shift(input logic [1:0] rate,
                                             input logic [1:0] frame);
    logic [1:0] s;
    s = 2'h0;
    if (rate == double_rate_mode && frame == frame_48k) s = 2'h1;
    if (rate == quadruple_rate_mode && frame == frame_48k) s = 2'h2;
    if (rate == quadruple_rate_mode && frame == frame_96k) s = 2'h1;
    return s;
  endfunction : split_shift

  // aes channel of an internal channel and sample index
  function automatic int slot_of(input int ch, input int idx, input logic [1:0] sh);
    return (ch << sh) + idx;
  endfunction : slot_of

  //////////////////////////////////////////////////////////////////////////
  // register slave, system clock
  logic [`AMUX_CTRL_W-1:0] ctrl_r, ctrl_nxt;     // control word
  logic                    ack_r, ack_nxt;       // answer cycle
  logic [31:0]             rdata_r, rdata_nxt;   // read data
  logic                    lock_m1_r, lock_m2_r; // lock sync into system
  logic                    lock_l_r;             // lock flag, link clock
  logic [31:0]             rate_hz;              // internal rate in hz
  logic                    req;

  assign req                 = avs_read_in | avs_write_in;
  // one wait cycle, then the answer
  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out    = rdata_r;

  // decode and next values
  always_comb begin
    ctrl_nxt  = ctrl_r;
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    // internal rate is base shifted by speed
    rate_hz = (ctrl_r[`AMUX_CTRL_BASE48] ? `AMUX_BASE_48_HZ : `AMUX_BASE_441_HZ)
              << ctrl_r[`AMUX_CTRL_RATE_LO +: 2];
    if (req && !ack_r) begin
      ack_nxt   = 1'b1;
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address_in)
        `AMUX_OFS_CTRL: begin
          rdata_nxt[`AMUX_CTRL_W-1:0] = ctrl_r;
        end
        `AMUX_OFS_STAT: begin
          rdata_nxt[`AMUX_STAT_LOCK] = lock_m2_r;
          rdata_nxt[`AMUX_STAT_SHIFT_LO +: 2] =
            split_shift(ctrl_r[`AMUX_CTRL_RATE_LO +: 2], ctrl_r[`AMUX_CTRL_FRAME_LO +: 2]);
        end
        `AMUX_OFS_RATE: begin
          rdata_nxt = rate_hz;
        end
        // unmapped: reads zero, writes ignored
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
    // write lands in the answer cycle, the edge the master sees waitrequest low
    if (avs_write_in && ack_r && avs_byteenable_in[0] &&
        avs_address_in == `AMUX_OFS_CTRL) begin
      ctrl_nxt = avs_writedata_in[`AMUX_CTRL_W-1:0];
    end
  end

  // register stage, frozen while the enable is low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_r    <= `AMUX_CTRL_RST;
      ack_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      lock_m1_r <= 1'b0;
      lock_m2_r <= 1'b0;
    end else if (clk_en_in) begin
      ctrl_r    <= ctrl_nxt;
      ack_r     <= ack_nxt;
      rdata_r   <= rdata_nxt;
      lock_m1_r <= lock_l_r;
      lock_m2_r <= lock_m1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // crossings into the link clock
  // control is quasi-static, so a level sync per bit is enough;
  // software must not expect the split to change mid-frame
  logic [`AMUX_CTRL_W+2:0] ls1_r, ls2_r;        // ctrl, reset, enable, wck
  logic                    lrst, len, wck_s, wck_d_r;
  logic [1:0]              sh;                  // split shift in use
  logic                    refsel;

  always_ff @(posedge link_clk_in) begin
    ls1_r <= {ctrl_r, srst_in, clk_en_in, wck_in};
    ls2_r <= ls1_r;
  end
  assign lrst   = ls2_r[2];
  assign len    = ls2_r[1];
  assign wck_s  = ls2_r[0];
  assign sh     = split_shift(ls2_r[3+`AMUX_CTRL_RATE_LO +: 2],
                              ls2_r[3+`AMUX_CTRL_FRAME_LO +: 2]);
  assign refsel = ls2_r[3+`AMUX_CTRL_REFSEL];

  //////////////////////////////////////////////////////////////////////////
  // clock recovery: period measure, averaging, phase alignment
  logic [PW-1:0] cnt_r, cnt_nxt;    // cycles since last reference
  logic [PW-1:0] per_r, per_nxt;    // smoothed frame period
  logic [PW-1:0] ph_r, ph_nxt;      // recovered frame phase
  logic [PW-1:0] sc_r, sc_nxt;      // sub-sample phase
  logic [1:0]    si_r, si_nxt;      // sample index in frame
  logic          lock_nxt, ref_ev, ftick, itick, swrap;
  logic [PW-1:0] step;

  always_comb begin
    ref_ev   = refsel ? (wck_s & ~wck_d_r) : rx_valid_in[0];
    cnt_nxt  = cnt_r;
    per_nxt  = per_r;
    lock_nxt = lock_l_r;
    if (ref_ev) begin
      // restart at one so cnt_r equals the full period at the next reference
      cnt_nxt  = PW'(1);
      lock_nxt = (cnt_r >= PW'(PMIN)) && (cnt_r <= PW'(PMAX));
      // first-order smoothing strips edge jitter, tracks varipitch
      if (lock_nxt) per_nxt = per_r - (per_r >> 2) + (cnt_r >> 2);
    end else if (cnt_r > PW'(PMAX)) begin
      lock_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // phase follows the reference while locked; a reference one cycle
    // after a free-running wrap is absorbed, so no double frame pulse
    ftick  = (ph_r >= per_r - 1'b1) || (ref_ev && lock_l_r && (ph_r != '0));
    ph_nxt = ftick ? '0 : ph_r + 1'b1;
    // sub-ticks run at the split multiple of frame rate
    step   = per_r >> sh;
    swrap  = (sc_r >= step - 1'b1);
    itick  = ftick || (swrap && (si_r < ((2'h1 << sh) - 2'h1)));
    sc_nxt = (ftick || swrap) ? '0 : sc_r + 1'b1;
    si_nxt = ftick ? 2'h0 : (itick ? si_r + 2'h1 : si_r);
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      cnt_r    <= '0;
      per_r    <= PW'(PNOM);
      ph_r     <= '0;
      sc_r     <= '0;
      si_r     <= 2'h0;
      lock_l_r <= 1'b0;
      wck_d_r  <= 1'b0;
    end else if (len) begin
      cnt_r    <= cnt_nxt;
      per_r    <= per_nxt;
      ph_r     <= ph_nxt;
      sc_r     <= sc_nxt;
      si_r     <= si_nxt;
      lock_l_r <= lock_nxt;
      wck_d_r  <= wck_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive realignment: two words held per link
  logic [2*W-1:0] h0_r [NLINK];
  logic [2*W-1:0] h1_r [NLINK];
  logic [2*W-1:0] h0_nxt [NLINK];
  logic [2*W-1:0] h1_nxt [NLINK];
  logic [1:0]     hc_r [NLINK];
  logic [1:0]     hc_nxt [NLINK];
  logic           all_have;

  // release a frame only when every link has one
  always_comb begin
    all_have = 1'b1;
    for (int l = 0; l < NLINK; l++) begin
      if (hc_r[l] == 2'h0) all_have = 1'b0;
    end
    for (int l = 0; l < NLINK; l++) begin
      h0_nxt[l] = h0_r[l];
      h1_nxt[l] = h1_r[l];
      hc_nxt[l] = hc_r[l];
      if (all_have) begin
        h0_nxt[l] = h1_r[l];
        hc_nxt[l] = hc_r[l] - 2'h1;
      end
      if (rx_valid_in[l]) begin
        if (hc_nxt[l] == 2'h0) begin
          h0_nxt[l] = {rx_left_in[l*W +: W], rx_right_in[l*W +: W]};
        end else begin
          h1_nxt[l] = {rx_left_in[l*W +: W], rx_right_in[l*W +: W]};
        end
        if (hc_nxt[l] != 2'h2) hc_nxt[l] = hc_nxt[l] + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sample split and join across aes channels
  logic [W-1:0]       txb_r [NCH];   // outgoing frame being gathered
  logic [W-1:0]       txb_nxt [NCH];
  logic [W-1:0]       rxb_r [NCH];   // last aligned received frame
  logic [W-1:0]       rxb_nxt [NCH];
  logic [NLINK*W-1:0] txl_nxt, txr_nxt;
  logic [NLINK*48-1:0] irx_nxt;
  logic               tick_r, fstb_r;
  logic [1:0]         idx_r;

  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      txb_nxt[k] = txb_r[k];
      // link l: channel 2l left, 2l+1 right
      rxb_nxt[k] = all_have ? ((k % 2 == 0) ? h0_r[k/2][2*W-1:W] : h0_r[k/2][W-1:0])
                            : rxb_r[k];
    end
    // gather: words stored as they come, 24 bits untouched
    if (tick_r) begin
      for (int c = 0; c < NCH; c++) begin
        if (c < (NCH >> sh)) txb_nxt[slot_of(c, int'(idx_r), sh)] = int_tx_in[c*W +: W];
      end
    end
    // frame goes out on the recovered tick
    txl_nxt = tx_left_out;
    txr_nxt = tx_right_out;
    if (ftick) begin
      for (int l = 0; l < NLINK; l++) begin
        txl_nxt[l*W +: W] = txb_r[2*l];
        txr_nxt[l*W +: W] = txb_r[2*l+1];
      end
    end
    // no split: channel k is aes channel k
    irx_nxt = int_rx_out;
    if (itick) begin
      irx_nxt = '0;
      for (int c = 0; c < NCH; c++) begin
        if (c < (NCH >> sh)) irx_nxt[c*W +: W] = rxb_r[slot_of(c, int'(si_nxt), sh)];
      end
    end
  end

  // link clock register stage for hold, split and outputs
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      for (int l = 0; l < NLINK; l++) begin
        h0_r[l] <= '0;
        h1_r[l] <= '0;
        hc_r[l] <= 2'h0;
      end
      for (int k = 0; k < NCH; k++) begin
        txb_r[k] <= '0;
        rxb_r[k] <= '0;
      end
      tx_left_out  <= '0;
      tx_right_out <= '0;
      int_rx_out   <= '0;
      tick_r       <= 1'b0;
      idx_r        <= 2'h0;
      fstb_r       <= 1'b0;
    end else if (len) begin
      h0_r         <= h0_nxt;
      h1_r         <= h1_nxt;
      hc_r         <= hc_nxt;
      txb_r        <= txb_nxt;
      rxb_r        <= rxb_nxt;
      tx_left_out  <= txl_nxt;
      tx_right_out <= txr_nxt;
      int_rx_out   <= irx_nxt;
      tick_r       <= itick;
      idx_r        <= si_nxt;
      fstb_r       <= ftick;
    end
  end

  // word clock high for first half of recovered frame
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      wck_out <= 1'b0;
    end else if (len) begin
      wck_out <= (ph_nxt < (per_r >> 1));
    end
  end

  // all paths carry the full 24-bit word
  assign tx_strobe_out = fstb_r;
  assign int_tick_out  = tick_r;
  assign int_index_out = idx_r;
endmodule : amux_core

// File: amux_pkg.sv
// amux types: internal speed modes and link frame formats
package amux_pkg;
  // internal sample speed against the base rate
  typedef enum logic [1:0] {
    single_rate_mode    = 2'h0,
    double_rate_mode    = 2'h1,
    quadruple_rate_mode = 2'h2
  } amux_rate_t;
  // frame format carried on the links
  typedef enum logic [1:0] {
    frame_48k    = 2'h0,
    frame_96k    = 2'h1,
    frame_native = 2'h2
  } amux_frame_t;
endpackage : amux_pkg

// File: testbench.sv
// amux testbench: register modes and link sample mapping
`timescale 1ns/1ps
module testbench;
  import amux_pkg::*;
  localparam int NL = 4;   // four stereo links
  logic              mclk_in = 1'b0;
  logic              lclk = 1'b0;
  logic              srst_in = 1'b1;
  logic [3:0]        adr = 4'h0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wdat = 32'h0;
  logic [3:0]        ben = 4'h0;
  logic [31:0]       rdat;
  logic              wreq;
  logic              itick;
  logic              tstb;
  logic [1:0]        iidx;
  logic [NL*24-1:0]  txl, txr, rxl, rxr;
  logic [NL-1:0]     rxv;
  logic [NL*48-1:0]  itx, irx;
  int                bad_count = 0;
  int                compares = 0;
  always #10 mclk_in = ~mclk_in;
  always #7.5 lclk = ~lclk;
  // internal channel c, sample idx carries its own coordinates
  always_comb for (int c = 0; c < 2 * NL; c++) itx[c*24+:24] = {8'(c), 8'(iidx), 8'h5a};
  // link 0 frame pulse doubles as the word clock reference
  amux_core #(.NLINK(NL), .LCLK_HZ(4800000)) dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .clk_en_in(1'b1), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(ben), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .link_clk_in(lclk), .rx_valid_in(rxv), .rx_left_in(rxl),
    .rx_right_in(rxr), .wck_in(rxv[0]), .tx_strobe_out(tstb), .tx_left_out(txl),
    .tx_right_out(txr), .wck_out(), .int_tick_out(itick), .int_index_out(iidx),
    .int_tx_in(itx), .int_rx_out(irx));
  amux_aes_far #(.NLINK(NL), .PER(100)) far (.link_clk_in(lclk), .rx_valid_out(rxv),
    .rx_left_out(rxl), .rx_right_out(rxr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge mclk_in);
    adr <= a;
    wdat <= d;
    ben <= be;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
  endtask : bus
  // bounded wait for a tick or a strobe, looked at mid-cycle where outputs settled
  task automatic wl(input bit strobe);
    int n;
    n = 0;
    do begin
      @(negedge lclk);
      n++;
    end while ((strobe ? tstb : itick) !== 1'b1 && n < 300);
    if (n >= 300) begin
      bad_count++;
      end_sim();
    end
  endtask : wl
  function automatic int sh(input int r, input int f);
    return (r == 1 && f == 0) ? 1 : (r == 2 && f == 0) ? 2 : (r == 2 && f == 1) ? 1 : 0;
  endfunction : sh
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    int s;
    // last mode also takes its reference from the word clock input
    logic [5:0] cfg [4] = '{6'h11, 6'h12, 6'h16, 6'h38};
    repeat (10) @(posedge mclk_in);
    srst_in <= 1'b0;
    bus(1'b0, 4'h0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    // every rate, frame and base combination
    for (int m = 0; m < 18; m++) begin
      bus(1'b1, 4'h0, 32'(m % 3 + m / 3 % 3 * 4 + m / 9 * 16), 4'h1, q);
      bus(1'b0, 4'h8, 32'h0, 4'hf, q);
      chk(q, (m / 9 ? 32'hbb80 : 32'hac44) << (m % 3));
      bus(1'b0, 4'h4, 32'h0, 4'hf, q);
      chk(32'(q[2:1]), 32'(sh(m % 3, m / 3 % 3)));
    end
    bus(1'b1, 4'h0, 32'h2, 4'h0, q);
    bus(1'b0, 4'h0, 32'h0, 4'hf, q);
    chk(q, 32'h1a);
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    // sample mapping in both directions for each split
    foreach (cfg[k]) begin
      s = sh(cfg[k][1:0], cfg[k][3:2]);
      bus(1'b1, 4'h0, 32'(cfg[k]), 4'h1, q);
      // the write answer carries old control bits, not the lock flag
      q = 32'h0;
      for (int n = 0; n < 400 && !q[0]; n++) bus(1'b0, 4'h4, 32'h0, 4'hf, q);
      chk(32'(q[0]), 32'h1);
      repeat (400) @(posedge mclk_in);
      // lock must still hold on the reference now selected
      bus(1'b0, 4'h4, 32'h0, 4'hf, q);
      chk(32'(q[0]), 32'h1);
      for (int t = 0; t < 4; t++) begin
        wl(1'b0);
        for (int c = 0; c < (2 * NL) >> s; c++)
          chk(32'(irx[c*24+:24]), {8'h0, 8'((c << s) + iidx), 16'hc3a5});
        wl(1'b1);
        for (int h = 0; h < 2 * NL; h++)
          chk(32'(h[0] ? txr[h/2*24+:24] : txl[h/2*24+:24]),
              {8'h0, 8'(h >> s), 8'(h & ((1 << s) - 1)), 8'h5a});
      end
    end
    end_sim();
  end
endmodule : testbench
bind amux_core amux_checker #(.NLINK(NLINK)) u_chk (.mclk_in(mclk_in), .srst_in(srst_in),
  .link_clk_in(link_clk_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .tx_strobe_out(tx_strobe_out),
  .tx_left_out(tx_left_out), .tx_right_out(tx_right_out), .int_tick_out(int_tick_out),
  .int_index_out(int_index_out), .int_rx_out(int_rx_out));
